// >>> inc/lcdpm_pkg.sv
package lcdpm_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] LCDPM_OFS_PA_OUT = 8'h00;
  localparam logic [7:0] LCDPM_OFS_PA_DIR = 8'h04;
  localparam logic [7:0] LCDPM_OFS_PB_OUT = 8'h08;
  localparam logic [7:0] LCDPM_OFS_PB_DIR = 8'h0c;
  localparam logic [7:0] LCDPM_OFS_PC_OUT = 8'h10;
  localparam logic [7:0] LCDPM_OFS_PC_DIR = 8'h14;
  localparam logic [7:0] LCDPM_OFS_PD_OUT = 8'h18;
  localparam logic [7:0] LCDPM_OFS_PD_DIR = 8'h1c;
  localparam logic [7:0] LCDPM_OFS_PE_OUT = 8'h20;
  localparam logic [7:0] LCDPM_OFS_PE_DIR = 8'h24;
  localparam logic [7:0] LCDPM_OFS_CTRL = 8'h28;
  localparam logic [7:0] LCDPM_OFS_SER_TX = 8'h2c;
  localparam logic [7:0] LCDPM_OFS_SER_RX = 8'h30;
  localparam logic [7:0] LCDPM_OFS_SER_STAT = 8'h34;
  localparam logic [7:0] LCDPM_OFS_IRQ_STAT = 8'h38;
  localparam logic [7:0] LCDPM_OFS_IRQ_CLR = 8'h3c;
  localparam logic [7:0] LCDPM_OFS_IRQ_EN = 8'h40;

  // ==========================================================
  // control register fields
  localparam int LCDPM_CTRL_PB7_PULL = 0;
  localparam int LCDPM_CTRL_PB6_PULL = 1;
  localparam int LCDPM_CTRL_RTF_EN = 2;
  localparam int LCDPM_CTRL_MASTER = 3;

  // interrupt status fields
  localparam int LCDPM_IRQ_W = 3;
  localparam int LCDPM_IRQ_EXT = 0;
  localparam int LCDPM_IRQ_SER = 1;
  localparam int LCDPM_IRQ_WAKE = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] LCDPM_RST_OUT = 8'hff;
  localparam logic [7:0] LCDPM_RST_DIR = 8'h00;
  localparam logic [7:0] LCDPM_RST_CTRL = 8'h03;
  localparam logic [7:0] LCDPM_RST_SER = 8'h00;
  localparam logic [LCDPM_IRQ_W-1:0] LCDPM_RST_IRQ = 3'h0;

  // ==========================================================
  // timing
  localparam int LCDPM_CLK_MHZ = 250;
  localparam int LCDPM_SCLK_KHZ = 1000;
  localparam int LCDPM_SCLK_HALF = (LCDPM_CLK_MHZ * 1000) / (2 * LCDPM_SCLK_KHZ);
  localparam int LCDPM_SER_BITS = 8;

  // ==========================================================
  // build options and carriers
  typedef enum {LCDPM_PB6_GPIO, LCDPM_PB6_TIMER, LCDPM_PB6_RTF} lcdpm_pb6_mode_t;
  typedef enum {LCDPM_PC67_XTAL, LCDPM_PC67_GPIO, LCDPM_PC67_SEG} lcdpm_pc67_mode_t;
  typedef enum {LCDPM_SER_IDLE, LCDPM_SER_LOW, LCDPM_SER_HIGH, LCDPM_SER_SLAVE} lcdpm_ser_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } lcdpm_pad8_t;

endpackage : lcdpm_pkg

// >>> core/lcdpm_pad_mux.sv
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps

// Summary of operation
// - The interrupt pad is always the serial data input and, by build option, also the external interrupt, pulled high in both roles.
// - Only a high-to-low transition on the interrupt pad is taken as an event, never a level.
// - The chip clear input is active low and its pad has no pull-high.
// - As master the serial clock pad gives exactly 8 pulses per transfer, then stops and stays high.
// - As slave the serial clock pad is an input and edges after the eighth are ignored.
// - Port B bit 4 in serial output use drives shift data out push-pull.
// - Port B bit 0 is a general port bit or the positive pulse-width push-pull output by build option.
// - The dedicated output pad is the negative pulse-width output or the sound output by build option.
// - Port B bit 7 in timer use feeds counter 0, its pull-high under software control.
// - Port B bit 6 in timer or resistance-frequency use feeds counter 1, pull-high and function enable by software.
// - While the resistance-frequency function is active, port B bits 2 and 3 lose their pull-high.
// - Each port A bit may be built as a wake-up source out of halt.
// - Port C, D and E bits are set by software as push-pull outputs or pulled-up inputs.
// - Ports C, D and E may each be built as upper LCD column drives instead of port bits.
// - Port C bits 6 and 7 may instead carry the watch crystal.
module lcdpm_pad_mux
  import lcdpm_pkg::*;
#(
  parameter bit INT_IS_EXT = 1'b1,
  parameter bit PB0_IS_PWM = 1'b0,
  parameter bit OUT_IS_SOUND = 1'b0,
  parameter bit PB4_IS_SHIFT_DATA_PAD_OUT = 1'b1,
  parameter bit PB5_IS_SCLK = 1'b1,
  parameter bit PB7_IS_TIMER = 1'b1,
  parameter lcdpm_pb6_mode_t PB6_MODE = LCDPM_PB6_RTF,
  parameter logic [7:0] WAKE_MASK = 8'hff,
  parameter bit PC_IS_SEG = 1'b0,
  parameter bit PD_IS_SEG = 1'b0,
  parameter bit PE_IS_SEG = 1'b0,
  parameter lcdpm_pc67_mode_t PC67_MODE = LCDPM_PC67_XTAL,
  parameter int SCLK_HALF = LCDPM_SCLK_HALF
) (
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  output logic irq, // level interrupt
  input wire logic [7:0] wake_port_a_in, // port a pad levels
  output lcdpm_pad8_t wake_port_a_pad, // port a drive
  input wire logic [7:0] port_b_in, // port b pad levels
  output lcdpm_pad8_t port_b_pad, // port b drive
  input wire logic [7:0] port_c_in, // port c pad levels
  output lcdpm_pad8_t port_c_pad, // port c drive
  input wire logic [7:0] port_d_in, // port d pad levels
  output lcdpm_pad8_t port_d_pad, // port d drive
  input wire logic [7:0] port_e_in, // port e pad levels
  output lcdpm_pad8_t port_e_pad, // port e drive
  input wire logic int_pad_in, // interrupt / serial input pad
  output logic int_pad_pu, // pull-high on that pad
  input wire logic chip_clear_n, // chip clear pad, active low
  output logic chip_reset_req, // synchronised clear request
  input wire logic positive_pulse_width_gen, // positive pwm source
  input wire logic negative_pulse_width_gen, // negative pwm source
  input wire logic sound_gen, // audio source
  output logic pulse_sound_pad, // dedicated output pad
  input wire logic [23:0] lcd_column_drive, // column drives 40..63
  output logic counter0_ext_in, // to counter 0
  output logic counter1_ext_in, // to counter 1
  output logic resistance_freq_in, // to r-to-f logic
  output logic serial_data_pad_in, // synchronised serial input
  output logic watch_xtal_en, // crystal on port c 6/7
  output logic halt_wake // wake pulse
);

  // ==========================================================
  // pad helpers
  function automatic lcdpm_pad8_t lcdpm_gpio(input logic [7:0] o, input logic [7:0] dir);
    lcdpm_gpio.out = o;
    lcdpm_gpio.oe = dir;
    lcdpm_gpio.pu = ~dir;
  endfunction : lcdpm_gpio

  function automatic lcdpm_pad8_t lcdpm_seg(input logic [7:0] s);
    lcdpm_seg.out = s;
    lcdpm_seg.oe = 8'hff;
    lcdpm_seg.pu = 8'h00;
  endfunction : lcdpm_seg

  // ==========================================================
  // input synchronisers
  logic [7:0] pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;
  logic [7:0] pc_s1_q, pc_s2_q, pd_s1_q, pd_s2_q, pe_s1_q, pe_s2_q;
  logic int_s1_q, int_s2_q, int_prev_q, clr_s1_q, clr_s2_q;
  logic [7:0] pa_prev_q;
  logic sclk_prev_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pa_s1_q <= 8'hff;
      pa_s2_q <= 8'hff;
      pb_s1_q <= 8'hff;
      pb_s2_q <= 8'hff;
      pc_s1_q <= 8'hff;
      pc_s2_q <= 8'hff;
      pd_s1_q <= 8'hff;
      pd_s2_q <= 8'hff;
      pe_s1_q <= 8'hff;
      pe_s2_q <= 8'hff;
      int_s1_q <= 1'b1;
      int_s2_q <= 1'b1;
      clr_s1_q <= 1'b1;
      clr_s2_q <= 1'b1;
    end else begin
      pa_s1_q <= wake_port_a_in;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= port_b_in;
      pb_s2_q <= pb_s1_q;
      pc_s1_q <= port_c_in;
      pc_s2_q <= pc_s1_q;
      pd_s1_q <= port_d_in;
      pd_s2_q <= pd_s1_q;
      pe_s1_q <= port_e_in;
      pe_s2_q <= pe_s1_q;
      int_s1_q <= int_pad_in;
      int_s2_q <= int_s1_q;
      clr_s1_q <= chip_clear_n;
      clr_s2_q <= clr_s1_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      int_prev_q <= 1'b1;
      pa_prev_q <= 8'hff;
      sclk_prev_q <= 1'b1;
    end else begin
      int_prev_q <= int_s2_q;
      pa_prev_q <= pa_s2_q;
      sclk_prev_q <= pb_s2_q[5];
    end
  end

  logic int_fall, sclk_rise, sclk_fall;
  logic [7:0] wake_fall;
  assign int_fall = int_prev_q & ~int_s2_q;
  assign wake_fall = pa_prev_q & ~pa_s2_q & WAKE_MASK;
  assign sclk_rise = ~sclk_prev_q & pb_s2_q[5];
  assign sclk_fall = sclk_prev_q & ~pb_s2_q[5];

  // ==========================================================
  // software registers
  logic [7:0] pa_out_q, pa_dir_q, pb_out_q, pb_dir_q, pc_out_q, pc_dir_q;
  logic [7:0] pd_out_q, pd_dir_q, pe_out_q, pe_dir_q, ctrl_q;
  logic [LCDPM_IRQ_W-1:0] irq_stat_q, irq_en_q;
  logic wr_tx;

  assign wr_tx = reg_wr && (reg_addr == LCDPM_OFS_SER_TX);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pa_out_q <= LCDPM_RST_OUT;
      pa_dir_q <= LCDPM_RST_DIR;
      pb_out_q <= LCDPM_RST_OUT;
      pb_dir_q <= LCDPM_RST_DIR;
      pc_out_q <= LCDPM_RST_OUT;
      pc_dir_q <= LCDPM_RST_DIR;
      pd_out_q <= LCDPM_RST_OUT;
      pd_dir_q <= LCDPM_RST_DIR;
      pe_out_q <= LCDPM_RST_OUT;
      pe_dir_q <= LCDPM_RST_DIR;
      ctrl_q <= LCDPM_RST_CTRL;
      irq_en_q <= LCDPM_RST_IRQ;
    end else if (reg_wr) begin
      unique case (reg_addr)
        LCDPM_OFS_PA_OUT: pa_out_q <= reg_wdata;
        LCDPM_OFS_PA_DIR: pa_dir_q <= reg_wdata;
        LCDPM_OFS_PB_OUT: pb_out_q <= reg_wdata;
        LCDPM_OFS_PB_DIR: pb_dir_q <= reg_wdata;
        LCDPM_OFS_PC_OUT: pc_out_q <= reg_wdata;
        LCDPM_OFS_PC_DIR: pc_dir_q <= reg_wdata;
        LCDPM_OFS_PD_OUT: pd_out_q <= reg_wdata;
        LCDPM_OFS_PD_DIR: pd_dir_q <= reg_wdata;
        LCDPM_OFS_PE_OUT: pe_out_q <= reg_wdata;
        LCDPM_OFS_PE_DIR: pe_dir_q <= reg_wdata;
        LCDPM_OFS_CTRL: ctrl_q <= reg_wdata;
        LCDPM_OFS_IRQ_EN: irq_en_q <= reg_wdata[LCDPM_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // serial shifter
  lcdpm_ser_t ser_q;
  logic [7:0] tx_sh_q, rx_sh_q;
  logic [3:0] bit_cnt_q;
  logic [15:0] div_q;
  logic sclk_q, ser_done;
  logic master;
  logic div_end;

  assign master = ctrl_q[LCDPM_CTRL_MASTER];
  assign div_end = (div_q == 16'(SCLK_HALF - 1));
  assign ser_done = ((ser_q == LCDPM_SER_HIGH) && div_end && (bit_cnt_q == 4'(LCDPM_SER_BITS)))
    || ((ser_q == LCDPM_SER_SLAVE) && (bit_cnt_q == 4'(LCDPM_SER_BITS)));
  assign serial_data_pad_in = int_s2_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ser_q <= LCDPM_SER_IDLE;
      tx_sh_q <= LCDPM_RST_SER;
      rx_sh_q <= LCDPM_RST_SER;
      bit_cnt_q <= 4'h0;
      div_q <= 16'h0000;
      sclk_q <= 1'b1;
    end else begin
      unique case (ser_q)
        LCDPM_SER_IDLE: begin
          sclk_q <= 1'b1;
          div_q <= 16'h0000;
          if (wr_tx) begin
            tx_sh_q <= reg_wdata;
            bit_cnt_q <= 4'h0;
            if (master) begin
              sclk_q <= 1'b0;
              ser_q <= LCDPM_SER_LOW;
            end else begin
              ser_q <= LCDPM_SER_SLAVE;
            end
          end
        end
        LCDPM_SER_LOW: begin
          div_q <= div_end ? 16'h0000 : div_q + 16'h0001;
          if (div_end) begin
            sclk_q <= 1'b1;
            rx_sh_q <= {rx_sh_q[6:0], int_s2_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            ser_q <= LCDPM_SER_HIGH;
          end
        end
        LCDPM_SER_HIGH: begin
          div_q <= div_end ? 16'h0000 : div_q + 16'h0001;
          if (div_end) begin
            if (bit_cnt_q == 4'(LCDPM_SER_BITS)) begin
              ser_q <= LCDPM_SER_IDLE;
            end else begin
              sclk_q <= 1'b0;
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
              ser_q <= LCDPM_SER_LOW;
            end
          end
        end
        LCDPM_SER_SLAVE: begin
          if (bit_cnt_q == 4'(LCDPM_SER_BITS)) begin
            ser_q <= LCDPM_SER_IDLE;
          end else if (sclk_rise) begin
            rx_sh_q <= {rx_sh_q[6:0], int_s2_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (sclk_fall && (bit_cnt_q != 4'h0)) begin
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
          end
        end
      endcase
    end
  end

  // ==========================================================
  // interrupt status
  logic [LCDPM_IRQ_W-1:0] irq_set, irq_clr;

  assign irq_set = {|wake_fall, ser_done, int_fall & INT_IS_EXT};
  assign irq_clr = (reg_wr && (reg_addr == LCDPM_OFS_IRQ_CLR)) ? reg_wdata[LCDPM_IRQ_W-1:0]
    : LCDPM_RST_IRQ;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_stat_q <= LCDPM_RST_IRQ;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      halt_wake <= 1'b0;
    end else begin
      halt_wake <= |wake_fall;
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // ==========================================================
  // read port
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        LCDPM_OFS_PA_OUT: reg_rdata <= pa_s2_q;
        LCDPM_OFS_PA_DIR: reg_rdata <= pa_dir_q;
        LCDPM_OFS_PB_OUT: reg_rdata <= pb_s2_q;
        LCDPM_OFS_PB_DIR: reg_rdata <= pb_dir_q;
        LCDPM_OFS_PC_OUT: reg_rdata <= pc_s2_q;
        LCDPM_OFS_PC_DIR: reg_rdata <= pc_dir_q;
        LCDPM_OFS_PD_OUT: reg_rdata <= pd_s2_q;
        LCDPM_OFS_PD_DIR: reg_rdata <= pd_dir_q;
        LCDPM_OFS_PE_OUT: reg_rdata <= pe_s2_q;
        LCDPM_OFS_PE_DIR: reg_rdata <= pe_dir_q;
        LCDPM_OFS_CTRL: reg_rdata <= ctrl_q;
        LCDPM_OFS_SER_TX: reg_rdata <= tx_sh_q;
        LCDPM_OFS_SER_RX: reg_rdata <= rx_sh_q;
        LCDPM_OFS_SER_STAT: reg_rdata <= {3'h0, ser_q != LCDPM_SER_IDLE, bit_cnt_q};
        LCDPM_OFS_IRQ_STAT: reg_rdata <= 8'(irq_stat_q);
        LCDPM_OFS_IRQ_EN: reg_rdata <= 8'(irq_en_q);
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // pad muxing
  logic rtf_act;
  assign rtf_act = (PB6_MODE == LCDPM_PB6_RTF) && ctrl_q[LCDPM_CTRL_RTF_EN];

  assign int_pad_pu = 1'b1;
  assign chip_reset_req = ~clr_s2_q;
  assign pulse_sound_pad = OUT_IS_SOUND ? sound_gen : negative_pulse_width_gen;
  assign counter0_ext_in = PB7_IS_TIMER & pb_s2_q[7];
  assign counter1_ext_in = (PB6_MODE != LCDPM_PB6_GPIO) & pb_s2_q[6];
  assign resistance_freq_in = rtf_act & pb_s2_q[6];
  assign watch_xtal_en = (PC67_MODE == LCDPM_PC67_XTAL);
  assign wake_port_a_pad = lcdpm_gpio(pa_out_q, pa_dir_q);

  lcdpm_pad8_t pb_io, pc_io, pc_sg;
  assign pb_io = lcdpm_gpio(pb_out_q, pb_dir_q);
  assign pc_io = lcdpm_gpio(pc_out_q, pc_dir_q);
  assign pc_sg = lcdpm_seg(lcd_column_drive[23:16]);

  always_comb begin
    port_b_pad = pb_io;
    if (PB0_IS_PWM) begin
      port_b_pad.out[0] = positive_pulse_width_gen;
      port_b_pad.oe[0] = 1'b1;
      port_b_pad.pu[0] = 1'b0;
    end
    if (rtf_act) begin
      port_b_pad.pu[3:2] = 2'b00;
    end
    port_b_pad.pu[4] = 1'b0;
    if (PB4_IS_SHIFT_DATA_PAD_OUT) begin
      port_b_pad.out[4] = tx_sh_q[7];
      port_b_pad.oe[4] = 1'b1;
    end
    port_b_pad.pu[5] = 1'b0;
    if (PB5_IS_SCLK) begin
      port_b_pad.out[5] = sclk_q;
      port_b_pad.oe[5] = master;
    end
    if (PB6_MODE != LCDPM_PB6_GPIO) begin
      port_b_pad.oe[6] = 1'b0;
      port_b_pad.pu[6] = ctrl_q[LCDPM_CTRL_PB6_PULL];
    end
    if (PB7_IS_TIMER) begin
      port_b_pad.oe[7] = 1'b0;
      port_b_pad.pu[7] = ctrl_q[LCDPM_CTRL_PB7_PULL];
    end
  end

  always_comb begin
    port_c_pad = PC_IS_SEG ? pc_sg : pc_io;
    unique case (PC67_MODE)
      LCDPM_PC67_XTAL: begin
        port_c_pad.oe[7:6] = 2'b00;
        port_c_pad.pu[7:6] = 2'b00;
        port_c_pad.out[7:6] = 2'b00;
      end
      LCDPM_PC67_GPIO: begin
        port_c_pad.out[7:6] = pc_io.out[7:6];
        port_c_pad.oe[7:6] = pc_io.oe[7:6];
        port_c_pad.pu[7:6] = pc_io.pu[7:6];
      end
      LCDPM_PC67_SEG: begin
        port_c_pad.out[7:6] = pc_sg.out[7:6];
        port_c_pad.oe[7:6] = pc_sg.oe[7:6];
        port_c_pad.pu[7:6] = pc_sg.pu[7:6];
      end
    endcase
  end

  assign port_d_pad = PD_IS_SEG ? lcdpm_seg(lcd_column_drive[15:8])
    : lcdpm_gpio(pd_out_q, pd_dir_q);
  assign port_e_pad = PE_IS_SEG ? lcdpm_seg(lcd_column_drive[7:0])
    : lcdpm_gpio(pe_out_q, pe_dir_q);

  // ==========================================================
  // checks
  logic [3:0] rise_cnt_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || (ser_q == LCDPM_SER_IDLE)) begin
      rise_cnt_q <= 4'h0;
    end else if ((ser_q == LCDPM_SER_LOW) && div_end) begin
      rise_cnt_q <= rise_cnt_q + 4'h1;
    end
  end

  sequence s_master_start;
    (ser_q == LCDPM_SER_IDLE) && wr_tx && master;
  endsequence
  sequence s_first_low;
    !sclk_q && (ser_q == LCDPM_SER_LOW);
  endsequence

  property p_master_begin;
    @(posedge ref_clk) disable iff (sys_rst) s_master_start |=> s_first_low;
  endproperty
  a_master_begin: assert property (p_master_begin) else $error("no first clock low");

  property p_master_eight;
    @(posedge ref_clk) disable iff (sys_rst)
      (ser_q == LCDPM_SER_HIGH) && div_end && (rise_cnt_q == 4'h8)
      |=> (ser_q == LCDPM_SER_IDLE) && sclk_q [*3];
  endproperty
  a_master_eight: assert property (p_master_eight) else $error("clock not parked high");

  property p_master_max;
    @(posedge ref_clk) disable iff (sys_rst) rise_cnt_q <= 4'h8;
  endproperty
  a_master_max: assert property (p_master_max) else $error("more than eight pulses");

  property p_slave_mask;
    @(posedge ref_clk) disable iff (sys_rst)
      (ser_q == LCDPM_SER_SLAVE) && (bit_cnt_q == 4'(LCDPM_SER_BITS))
      |=> (ser_q == LCDPM_SER_IDLE) && $stable(rx_sh_q);
  endproperty
  a_slave_mask: assert property (p_slave_mask) else $error("clock edge after eighth taken");

  property p_int_edge;
    @(posedge ref_clk) disable iff (sys_rst)
      INT_IS_EXT && int_prev_q && !int_s2_q |=> irq_stat_q[LCDPM_IRQ_EXT];
  endproperty
  a_int_edge: assert property (p_int_edge) else $error("falling edge missed");

  property p_int_level;
    @(posedge ref_clk) disable iff (sys_rst)
      !irq_stat_q[LCDPM_IRQ_EXT] && !(int_prev_q && !int_s2_q) |=> !irq_stat_q[LCDPM_IRQ_EXT];
  endproperty
  a_int_level: assert property (p_int_level) else $error("event without edge");

  property p_int_pull;
    @(posedge ref_clk) disable iff (sys_rst) int_pad_pu;
  endproperty
  a_int_pull: assert property (p_int_pull) else $error("interrupt pad pull missing");

  property p_clear_low;
    @(posedge ref_clk) disable iff (sys_rst) !chip_clear_n [*3] |-> chip_reset_req;
  endproperty
  a_clear_low: assert property (p_clear_low) else $error("clear not seen as active low");

  property p_shift_data_pad_out;
    @(posedge ref_clk) disable iff (sys_rst)
      PB4_IS_SHIFT_DATA_PAD_OUT |-> port_b_pad.oe[4] && (port_b_pad.out[4] == tx_sh_q[7]);
  endproperty
  a_shift_data_pad_out: assert property (p_shift_data_pad_out) else $error("shift data pad not driven");

  property p_timer0;
    @(posedge ref_clk) disable iff (sys_rst)
      PB7_IS_TIMER ##2 1'b1 |-> counter0_ext_in == $past(port_b_in[7], 2);
  endproperty
  a_timer0: assert property (p_timer0) else $error("counter 0 input wrong");

  property p_rtf_pull;
    @(posedge ref_clk) disable iff (sys_rst) rtf_act |-> port_b_pad.pu[3:2] == 2'b00;
  endproperty
  a_rtf_pull: assert property (p_rtf_pull) else $error("pull left on bits 2 and 3");

  property p_wake;
    @(posedge ref_clk) disable iff (sys_rst)
      |wake_fall |=> halt_wake && irq_stat_q[LCDPM_IRQ_WAKE];
  endproperty
  a_wake: assert property (p_wake) else $error("wake edge missed");

  property p_seg_e;
    @(posedge ref_clk) disable iff (sys_rst)
      PE_IS_SEG |-> (port_e_pad.oe == 8'hff) && (port_e_pad.out == lcd_column_drive[7:0]);
  endproperty
  a_seg_e: assert property (p_seg_e) else $error("column drive not on port e");

endmodule : lcdpm_pad_mux

// >>> tb/lcdpm_board.sv
`timescale 1ns/10ps

// ==========
// board side of the port b pads
module lcdpm_board
  import lcdpm_pkg::*;
(
  input wire logic clk, // system clock
  input wire lcdpm_pad8_t pad, // chip drive
  input wire logic [7:0] ext_v, // board drive level
  input wire logic [7:0] ext_en, // board drives pin
  output logic [7:0] lvl // resolved pad level
);
  logic t_q;
  always_ff @(posedge clk) begin
    t_q <= (t_q === 1'b1) ? 1'b0 : 1'b1;
  end
  // a floating pin wanders so a stale level is never read
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.oe[i]) lvl[i] = pad.out[i];
      else if (ext_en[i]) lvl[i] = ext_v[i];
      else if (pad.pu[i]) lvl[i] = 1'b1;
      else lvl[i] = t_q;
    end
  end
endmodule : lcdpm_board

// >>> tb/lcdpm_pad_mux_tb_top.sv
`timescale 1ns/10ps

// ==========
// pad mux bench
module lcdpm_pad_mux_tb_top;
  import lcdpm_pkg::*;
  logic ref_clk, sys_rst, reg_wr, reg_rd, irq, int_pad_in, int_pad_pu, chip_clear_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pa_in, pb_in, pc_in, ext_v, ext_en;
  logic chip_reset_req, pos_g, neg_g, snd_g, pso, c0, c1, rfi, sdi, xt, wk;
  logic [23:0] col;
  lcdpm_pad8_t pa, pb, pc, pd, pe;
  int n_errors = 0, checks = 0, cyc = 0, wakes = 0;

  lcdpm_pad_mux #(.SCLK_HALF(2), .PB0_IS_PWM(1'b1), .PE_IS_SEG(1'b1)) lcdpm_pad_mux_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .wake_port_a_in(pa_in), .wake_port_a_pad(pa), .port_b_in(pb_in), .port_b_pad(pb),
    .port_c_in(pc_in), .port_c_pad(pc), .port_d_in(8'hff), .port_d_pad(pd),
    .port_e_in(8'hff), .port_e_pad(pe), .int_pad_in(int_pad_in), .int_pad_pu(int_pad_pu),
    .chip_clear_n(chip_clear_n), .chip_reset_req(chip_reset_req),
    .positive_pulse_width_gen(pos_g), .negative_pulse_width_gen(neg_g), .sound_gen(snd_g),
    .pulse_sound_pad(pso), .lcd_column_drive(col), .counter0_ext_in(c0),
    .counter1_ext_in(c1), .resistance_freq_in(rfi), .serial_data_pad_in(sdi),
    .watch_xtal_en(xt), .halt_wake(wk));

  lcdpm_board lcdpm_board_inst (.clk(ref_clk), .pad(pb), .ext_v(ext_v), .ext_en(ext_en),
    .lvl(pb_in));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp

  task end_sim;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  always @(posedge ref_clk) begin
    cyc++;
    if (wk === 1'b1) wakes++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim;
    end
  end

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, e);
  endtask : chk

  task wait_n(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_n

  task t_static;
    chk(8'h28, 8'h03);
    chk(8'h14, 8'h00);
    chk(8'hfc, 8'h00);
    cmp(int_pad_pu, 1);
    cmp(pb.pu[3:2], 2'b11);
    cmp(pb.pu[7:6], 2'b11);
    wr(8'h14, 8'h0f);
    wr(8'h10, 8'h05);
    pc_in <= 8'h96;
    wait_n(1);
    cmp(pc.oe, 8'h0f);
    cmp(pc.pu, 8'h30);
    cmp(pc.out[3:0], 4'h5);
    cmp(xt, 1);
    cmp(pe.oe, 8'hff);
    cmp(pe.out, 8'h3c);
    cmp(pa.pu, 8'hff);
    cmp(pd.oe, 8'h00);
    @(posedge ref_clk);
    pos_g <= 1'b1;
    neg_g <= 1'b1;
    wait_n(1);
    cmp({pb.oe[0], pb.out[0], pso}, 3'b111);
    @(posedge ref_clk);
    neg_g <= 1'b0;
    snd_g <= 1'b1;
    wait_n(1);
    cmp(pso, 8'h00);
    chk(8'h10, 8'h96);
  endtask : t_static

  task t_timer;
    wr(8'h28, 8'h04); ext_v[7:6] <= 2'b01; wait_n(5);
    cmp({pb.pu[7:6], pb.pu[3:2]}, 4'h0);
    cmp({c0, c1, rfi}, 3'b011);
    @(posedge ref_clk);
    ext_v[7:6] <= 2'b10;
    wait_n(5);
    cmp({c0, c1, rfi}, 3'b100);
  endtask : t_timer

  task t_master;
    logic [7:0] sh;
    int n;
    logic prv;
    n = 0; sh = 0; prv = 1'b1;
    wr(8'h3c, 8'h07); wr(8'h28, 8'h08); wr(8'h2c, 8'ha5);
    repeat (80) begin
      wait_n(1);
      if (prv && !pb.out[5]) n++;
      if (!prv && pb.out[5]) sh = {sh[6:0], pb.out[4]};
      prv = pb.out[5];
    end
    cmp(n[7:0], 8'd8);
    cmp(sh, 8'ha5);
    cmp({pb.oe[4], pb.out[5]}, 2'b11);
    chk(8'h38, 8'h02);
  endtask : t_master

  task t_slave;
    logic [15:0] d;
    d = 16'hb35a;
    wr(8'h28, 8'h00); wr(8'h2c, 8'h00);
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      int_pad_in <= d[15-i];
      ext_v[5] <= 1'b0;
      wait_n(4);
      @(posedge ref_clk);
      ext_v[5] <= 1'b1;
      wait_n(4);
    end
    chk(8'h30, d[15:8]);
  endtask : t_slave

  task t_events;
    @(posedge ref_clk);
    int_pad_in <= 1'b1;
    wait_n(4);
    wr(8'h3c, 8'h07); wr(8'h40, 8'h01);
    int_pad_in <= 1'b0; wait_n(6);
    cmp(irq, 1);
    cmp(sdi, 8'h00);
    wr(8'h3c, 8'h01); wait_n(4);
    cmp(irq, 0);
    wr(8'h40, 8'h04); pa_in <= 8'h7f; wait_n(6);
    cmp(irq, 1);
    cmp(wakes[7:0], 8'h01);
    wr(8'h3c, 8'h04); wait_n(1);
    cmp(irq, 0);
    @(posedge ref_clk);
    chip_clear_n <= 1'b0;
    wait_n(5);
    cmp(chip_reset_req, 1);
    @(posedge ref_clk);
    chip_clear_n <= 1'b1;
    wait_n(5);
    cmp(chip_reset_req, 0);
  endtask : t_events

  initial begin
    sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    pa_in = 8'hff; ext_v = 8'hff; ext_en = 8'he0; int_pad_in = 1'b1; chip_clear_n = 1'b1;
    pos_g = 1'b0; neg_g = 1'b0; snd_g = 1'b0; col = 24'h00003c;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_static;
    t_timer;
    t_master;
    t_slave;
    t_events;
    end_sim;
  end
endmodule : lcdpm_pad_mux_tb_top
